// ---- ccm_pkg.sv ----
// Package: register map, field positions and mode encodings for the capture/compare module
package ccm_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses on the bus)
  // ----------------------------------------------------------------
  localparam logic [3:0] MODE_OFFSET = 4'h0;
  localparam logic [3:0] CAPCMP_OFFSET = 4'h4;
  localparam logic [3:0] COUNT_OFFSET = 4'h8;
  localparam logic [3:0] FLAG_OFFSET = 4'hC;

  // ----------------------------------------------------------------
  // Mode register fields
  // ----------------------------------------------------------------
  localparam int WIDE_BIT = 7;
  localparam int CMP_EN_BIT = 6;
  localparam int RISE_CAP_BIT = 5;
  localparam int FALL_CAP_BIT = 4;
  localparam int MATCH_BIT = 3;
  localparam int TOGGLE_BIT = 2;
  localparam int PWM_BIT = 1;
  localparam int IRQ_MASK_BIT = 0;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [15:0] CAPCMP_RESET = 16'h0000;
  localparam logic [15:0] COUNT_RESET = 16'h0000;

  // Operating modes decoded from the mode bits, one-hot
  typedef enum logic [4:0] {
    MODE_IDLE = 5'b00001,
    MODE_TOGGLE = 5'b00010,
    MODE_PWM8 = 5'b00100,
    MODE_PWM16 = 5'b01000,
    MODE_FREQ = 5'b10000
  } op_mode_t;

endpackage

// ---- edge_detect.sv ----
// Falling-edge detector for the module input pin
`timescale 1ns/1ps
module edge_detect (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Pin and result
  input wire logic pin,
  output logic fall
);
  logic prev_q;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      prev_q <= 1'b1;
    else
      prev_q <= pin;
  end

  assign fall = prev_q & ~pin;
endmodule // edge_detect

// ---- ccm_mode_ctrl.sv ----
// Capture/compare module: mode control, match, toggle, PWM, capture and flag
`timescale 1ns/1ps
module ccm_mode_ctrl (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Counter time base
  input wire logic count_en,
  // Module pin
  input wire logic module_io_pin_in,
  output logic module_io_pin_out,
  output logic module_io_pin_oe,
  // Interrupt request
  output logic flag_irq
);
  import ccm_pkg::*;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] mode_q;
  logic [15:0] capcmp_q;
  logic [15:0] count_q;
  logic flag_q;
  logic out_q;
  logic ack_q;
  logic [31:0] rdata_q;
  logic fall;
  op_mode_t mode;
  logic match;
  logic capture;
  logic bus_req;
  logic bus_wr;

  logic falling_capture_enable;
  logic match_flag_enable;
  logic toggle_on_match_enable;
  logic pulse_width_enable;
  logic wide_pulse_select;
  logic flag_interrupt_mask;

  assign falling_capture_enable = mode_q[FALL_CAP_BIT];
  assign match_flag_enable = mode_q[MATCH_BIT];
  assign toggle_on_match_enable = mode_q[TOGGLE_BIT];
  assign pulse_width_enable = mode_q[PWM_BIT];
  assign wide_pulse_select = mode_q[WIDE_BIT];
  assign flag_interrupt_mask = mode_q[IRQ_MASK_BIT];

  // Lane-merge helper, used for the capture/compare and count registers
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] sel);
    merge16 = {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
  endfunction

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  // Frequency output outranks both plain toggle and modulation
  always_comb
  begin
    mode = MODE_IDLE;
    if (toggle_on_match_enable && pulse_width_enable)
    begin
      mode = MODE_FREQ;
    end
    else if (pulse_width_enable)
    begin
      // Wide select only matters once modulation is on
      mode = wide_pulse_select ? MODE_PWM16 : MODE_PWM8;
    end
    else if (toggle_on_match_enable)
    begin
      mode = MODE_TOGGLE;
    end
  end

  edge_detect u_edge (
    .clk(clk),
    .rstn(rstn),
    .pin(module_io_pin_in),
    .fall(fall)
  );

  // Match in 8-bit PWM only looks at the low byte so the period is 256 counts
  assign match = (mode == MODE_PWM8 || mode == MODE_FREQ) ?
                 (count_q[7:0] == capcmp_q[7:0]) : (count_q == capcmp_q);
  assign capture = falling_capture_enable && fall;

  assign bus_req = wb_cyc_i && wb_stb_i && !ack_q;
  assign bus_wr = bus_req && wb_we_i;

  // ----------------------------------------------------------------
  // Register write strobes
  // ----------------------------------------------------------------
  // One decode per register keeps every write gated by the same request
  // qualifier, so a request held through its ack cannot write twice
  function automatic logic reg_hit(input logic [3:0] adr, input logic [3:0] offset);
    reg_hit = (adr == offset);
  endfunction

  logic wr_mode;
  logic wr_capcmp;
  logic wr_count;
  logic wr_flag;
  logic flag_clear;

  assign wr_mode = bus_wr && reg_hit(wb_adr_i, MODE_OFFSET) && wb_sel_i[0];
  assign wr_capcmp = bus_wr && reg_hit(wb_adr_i, CAPCMP_OFFSET);
  assign wr_count = bus_wr && reg_hit(wb_adr_i, COUNT_OFFSET);
  assign wr_flag = bus_wr && reg_hit(wb_adr_i, FLAG_OFFSET) && wb_sel_i[0];
  assign flag_clear = wr_flag && wb_dat_i[0];

  // ----------------------------------------------------------------
  // Bus handshake and read data
  // ----------------------------------------------------------------
  // Registered ack costs one wait state but keeps the decode off the ack path
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ack_q <= 1'b0;
    end
    else
    begin
      ack_q <= bus_req;
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rdata_q <= 32'h00000000;
    end
    else if (bus_req)
    begin
      case (wb_adr_i)
        MODE_OFFSET:
        begin
          rdata_q <= {24'h000000, mode_q};
        end
        CAPCMP_OFFSET:
        begin
          rdata_q <= {16'h0000, capcmp_q};
        end
        COUNT_OFFSET:
        begin
          rdata_q <= {16'h0000, count_q};
        end
        FLAG_OFFSET:
        begin
          rdata_q <= {31'h00000000, flag_q};
        end
        default:
        begin
          rdata_q <= 32'h00000000;
        end
      endcase
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdata_q;

  // ----------------------------------------------------------------
  // Mode register
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      mode_q <= MODE_RESET;
    end
    else if (wr_mode)
    begin
      mode_q <= wb_dat_i[7:0];
    end
  end

  // ----------------------------------------------------------------
  // Counter: advances on the time-base enable, software may preset it
  // ----------------------------------------------------------------
  // A preset in the same cycle as a tick wins; the tick is lost
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      count_q <= COUNT_RESET;
    end
    else if (wr_count)
    begin
      count_q <= merge16(count_q, wb_dat_i, wb_sel_i);
    end
    else if (count_en)
    begin
      count_q <= count_q + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // Capture/compare register; a capture takes priority over a write
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      capcmp_q <= CAPCMP_RESET;
    end
    else if (capture)
    begin
      capcmp_q <= count_q;
    end
    else if (wr_capcmp)
    begin
      capcmp_q <= merge16(capcmp_q, wb_dat_i, wb_sel_i);
    end
  end

  // ----------------------------------------------------------------
  // Flag: set by hardware wins over a software clear (write 1 to clear)
  // ----------------------------------------------------------------
  logic match_event;
  logic flag_set;

  // A capture sets the flag even with match flagging off
  assign match_event = match_flag_enable && match;
  assign flag_set = match_event || capture;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      flag_q <= 1'b0;
    end
    else if (flag_set)
    begin
      flag_q <= 1'b1;
    end
    else if (flag_clear)
    begin
      flag_q <= 1'b0;
    end
  end

  assign flag_irq = flag_q && flag_interrupt_mask;

  // ----------------------------------------------------------------
  // Output pin
  // ----------------------------------------------------------------
  // PWM: high from match until the period wraps to zero, then low
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      out_q <= 1'b0;
    end
    else
    begin
      case (mode)
        MODE_TOGGLE:
        begin
          // A counter parked on the match value flips the pin every cycle
          if (match)
            out_q <= ~out_q;
        end
        MODE_FREQ:
        begin
          // Gated by the time base so a stopped counter does not oscillate
          if (match && count_en)
            out_q <= ~out_q;
        end
        MODE_PWM8:
        begin
          if (match)
            out_q <= 1'b1;
          else if (count_q[7:0] == 8'h00)
            out_q <= 1'b0;
        end
        MODE_PWM16:
        begin
          if (match)
            out_q <= 1'b1;
          else if (count_q == 16'h0000)
            out_q <= 1'b0;
        end
        default:
        begin
          out_q <= out_q;
        end
      endcase
    end
  end

  // The pin is only driven while a mode owns it; idle leaves it to the board
  assign module_io_pin_out = out_q;
  assign module_io_pin_oe = (mode != MODE_IDLE);
endmodule // ccm_mode_ctrl

// ---- ccm_mode_ctrl_chk.sv ----
// Checker: bus, mask and pin assertions for the capture/compare module
`timescale 1ns/1ps
module ccm_mode_ctrl_chk (
  // Clock, reset and bus
  input logic clk,
  input logic rstn,
  input logic wb_cyc_i,
  input logic wb_stb_i,
  input logic wb_we_i,
  input logic [3:0] wb_adr_i,
  input logic [31:0] wb_dat_i,
  input logic [31:0] wb_dat_o,
  input logic wb_ack_o,
  // Pin and request
  input logic module_io_pin_out,
  input logic module_io_pin_oe,
  input logic flag_irq
);
  logic [7:0] mode_q;
  logic idle;
  assign idle = mode_q[2:1] == 2'b00;
  // Shadow of the mode register; the bench always writes all lanes
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
      mode_q <= 8'h00;
    else if (wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_adr_i == 4'h0)
      mode_q <= wb_dat_i[7:0];
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  ack_cause_a: assert property ($rose(wb_ack_o) |-> $past(wb_stb_i))
    else $error("ack unasked");
  irq_mask_a: assert property (!mode_q[0] |-> !flag_irq)
    else $error("irq not masked");
  pin_enable_a: assert property (module_io_pin_oe == !idle)
    else $error("pin enable");
  idle_pin_a: assert property (idle && $past(idle) |=> $stable(module_io_pin_out))
    else $error("idle pin moved");
  unmapped_zero_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i[1:0] != 2'b00
    |-> wb_dat_o == 32'h0) else $error("unmapped data");
  mode_read_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 4'h0
    |-> wb_dat_o[7:0] == mode_q) else $error("mode readback");
endmodule // ccm_mode_ctrl_chk

bind ccm_mode_ctrl ccm_mode_ctrl_chk chk_i (.clk(clk), .rstn(rstn), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .module_io_pin_out(module_io_pin_out),
  .module_io_pin_oe(module_io_pin_oe), .flag_irq(flag_irq));

// ---- testbench.sv ----
// Testbench: self-checking scenarios for the capture/compare module
`timescale 1ns/1ps
module testbench;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, cen = 1'b0, pin = 1'b1;
  logic [3:0] adr = 4'h0;
  logic [31:0] wd = 32'h0, rdat, q;
  logic ack, pout, poe, irq;
  int fails = 0, checks_done = 0, cycles = 0;
  always #25 clk = ~clk;
  ccm_mode_ctrl dut (.clk(clk), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wd), .wb_dat_o(rdat), .wb_ack_o(ack),
    .count_en(cen), .module_io_pin_in(pin), .module_io_pin_out(pout),
    .module_io_pin_oe(poe), .flag_irq(irq));
  task automatic conclude();
    if (fails == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic ok, input string m);
    checks_done++;
    if (ok !== 1'b1)
    begin
      fails++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask
  // Ack is seen at the edge after it rises, so data is taken there
  task automatic bus(input logic w, input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wd <= {16'h0000, d};
    do @(posedge clk); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] e, input string m);
    bus(1'b0, a, 16'h0000);
    chk(q[15:0] === e, m);
  endtask
  // Mode goes idle first so presets cannot raise stray matches
  task automatic setup(input logic [7:0] m, input logic [15:0] cc, input logic [15:0] cnt);
    bus(1'b1, 4'h0, 16'h0000);
    bus(1'b1, 4'hC, 16'h0001);
    bus(1'b1, 4'h4, cc);
    bus(1'b1, 4'h8, cnt);
    bus(1'b1, 4'h0, {8'h00, m});
  endtask
  task automatic run(input int n);
    cen <= 1'b1;
    repeat (n) @(posedge clk);
    cen <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  task automatic regs_test();
    rd(4'h0, 16'h0000, "mode reset");
    bus(1'b1, 4'h0, 16'h00B5);
    rd(4'h0, 16'h00B5, "mode readback");
    bus(1'b1, 4'h2, 16'hFFFF);
    rd(4'h2, 16'h0000, "unmapped read");
  endtask
  task automatic match_test();
    setup(8'h09, 16'h0005, 16'h0000);
    run(8);
    rd(4'hC, 16'h0001, "match flag");
    chk(irq === 1'b1, "irq missing");
    bus(1'b1, 4'h0, 16'h0008);
    chk(irq === 1'b0, "irq unmasked");
    setup(8'h01, 16'h0005, 16'h0000);
    run(8);
    rd(4'hC, 16'h0000, "flag without match");
  endtask
  task automatic capture_test();
    for (int i = 0; i < 2; i++)
    begin
      setup(i ? 8'h10 : 8'h00, 16'h0000, 16'h1234);
      pin <= 1'b0;
      repeat (4) @(posedge clk);
      pin <= 1'b1;
      rd(4'h4, i ? 16'h1234 : 16'h0000, "capture value");
      rd(4'hC, i ? 16'h0001 : 16'h0000, "capture flag");
    end
  endtask
  task automatic toggle_test();
    logic was;
    for (int i = 0; i < 2; i++)
    begin
      setup(i ? 8'h06 : 8'h04, 16'h0003, 16'h0000);
      was = pout;
      run(8);
      chk(pout === ~was, "toggle");
    end
  endtask
  // Count passes a wrap, then low byte 80 but not 0180
  task automatic pwm_test();
    for (int i = 0; i < 2; i++)
    begin
      setup(i ? 8'h82 : 8'h02, 16'h0180, 16'hFFF0);
      run(160);
      chk(pout === (i == 0), "pwm level");
    end
  endtask
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fails++;
      conclude();
    end
  end
  initial
  begin
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    regs_test();
    match_test();
    capture_test();
    toggle_test();
    pwm_test();
    conclude();
  end
endmodule // testbench
